/* src/ihm_pkg.sv */
// constants for the two-wire master host controller
// assumes the engine shares clk and answers a register read one cycle later
package ihm_pkg;
  // engine register indices on the engine's own port
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_CTRL   = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_MODE   = 3'h3;
  localparam logic [2:0] REG_EXT    = 3'h4;
  localparam logic [2:0] REG_SADDR  = 3'h5;
  // iic_control_reg bits
  localparam int CTL_INT_ENABLE = 7;
  localparam int CTL_MASTER     = 5;
  localparam int CTL_TRANSMIT   = 4;
  localparam int CTL_ACK_CHECK  = 3;
  localparam int CTL_BUS_BUSY   = 2;
  localparam int CTL_INT_FLAG   = 1;
  localparam int CTL_START_STOP = 0;
  // iic_status_reg bits
  localparam int STA_ACK_BIT    = 0;
  localparam int STA_RX_FULL    = 1;
  localparam int STA_XFER_DONE  = 2;
  // iic_mode_reg, serial_ctrl_ext_reg and slave address register fields
  localparam int MODE_ORDER     = 7;
  localparam int EXT_HANDSHAKE  = 0;
  localparam int SADDR_FORMAT   = 0;
  // host wishbone byte offsets
  localparam logic [4:0] WB_CMD    = 5'h00;
  localparam logic [4:0] WB_TXD    = 5'h04;
  localparam logic [4:0] WB_RXD    = 5'h08;
  localparam logic [4:0] WB_STATUS = 5'h0c;
  localparam logic [4:0] WB_CFG    = 5'h10;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // host commands
  typedef enum logic [2:0] {
    IHM_CMD_NONE  = 3'h0,
    IHM_CMD_START = 3'h1,
    IHM_CMD_WRITE = 3'h2,
    IHM_CMD_READ  = 3'h3,
    IHM_CMD_RDPRE = 3'h4,
    IHM_CMD_RDFIN = 3'h5,
    IHM_CMD_STOP  = 3'h6,
    IHM_CMD_CFG   = 3'h7
  } ihm_cmd_t;
endpackage : ihm_pkg

/* src/ihm_acc_if.sv */
// one engine register access between sequencer and port driver
// assumes both ends on the same clock
`timescale 1ns/1ps
interface ihm_acc_if;
  logic       req;
  logic       we;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       done;
  logic [7:0] rdata;
  modport seq  (output req, output we, output addr, output wdata,
                input done, input rdata);
  modport port (input req, input we, input addr, input wdata,
                output done, output rdata);
endinterface : ihm_acc_if

/* src/ihm_dev_port.sv */
// drives the engine's register port, one access at a time
// assumes engine read data is valid the cycle after the read strobe
`timescale 1ns/1ps
module ihm_dev_port
  import ihm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  ihm_acc_if.port         acc,
  output logic      [2:0] dev_addr,
  output logic      [7:0] dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata
);
  typedef enum logic [1:0] {P_IDLE, P_STROBE, P_SAMPLE, P_DONE} ihm_port_t;
  ihm_port_t  st_q;
  logic [7:0] rdata_q;

  wire take = (st_q == P_IDLE) && acc.req;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= P_IDLE;
      dev_addr  <= 3'h0;
      dev_wdata <= 8'h00;
      dev_wr    <= 1'b0;
      dev_rd    <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      unique case (st_q)
        P_IDLE:   if (take) st_q <= P_STROBE;
        P_STROBE: st_q <= P_SAMPLE;
        P_SAMPLE: st_q <= P_DONE;
        P_DONE:   st_q <= P_IDLE;
      endcase
      dev_wr <= take && acc.we;
      dev_rd <= take && !acc.we;
      if (take) begin
        dev_addr  <= acc.addr;
        dev_wdata <= acc.wdata;
      end
      if (st_q == P_SAMPLE) rdata_q <= dev_rdata;
    end
  end

  // done stands in the gap cycle so a held request is not taken twice
  assign acc.done  = (st_q == P_DONE);
  assign acc.rdata = rdata_q;
endmodule : ihm_dev_port

/* src/ihm_wb_slave.sv */
// classic wishbone slave holding the host's own registers
// assumes a single-cycle master that holds the request until ack
`timescale 1ns/1ps
module ihm_wb_slave
  import ihm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  txd,
  output logic      [7:0]  cfg,
  output logic             cmd_valid,
  output ihm_cmd_t         cmd,
  input  wire logic [7:0]  rxd,
  input  wire logic [3:0]  status
);
  wire acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge where the master samples ack
  wire wr_b0 = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire hit_cmd = (wb_adr_i == WB_CMD);
  wire hit_txd = (wb_adr_i == WB_TXD);
  wire hit_cfg = (wb_adr_i == WB_CFG);
  logic [31:0] rd_mux;

  // unmapped offsets read zero and still ack
  assign rd_mux = (wb_adr_i == WB_RXD)    ? {24'h000000, rxd} :
                  (wb_adr_i == WB_STATUS) ? {28'h0000000, status} :
                  hit_txd                 ? {24'h000000, txd} :
                  hit_cfg                 ? {24'h000000, cfg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      txd       <= 8'h00;
      cfg       <= CFG_RESET;
      cmd_valid <= 1'b0;
      cmd       <= IHM_CMD_NONE;
    end else begin
      wb_ack_o  <= acc;
      wb_dat_o  <= acc ? rd_mux : 32'h00000000;
      cmd_valid <= wr_b0 && hit_cmd;
      if (wr_b0 && hit_cmd) cmd <= ihm_cmd_t'(wb_dat_i[2:0]);
      if (wr_b0 && hit_txd) txd <= wb_dat_i[7:0];
      if (wr_b0 && hit_cfg) cfg <= wb_dat_i[7:0];
    end
  end
endmodule : ihm_wb_slave

/* src/ihm_top.sv */
// host controller: runs the software procedure of a two-wire master engine
// assumes engine on clk; software orders commands over classic wishbone
`timescale 1ns/1ps
// Operation
// - mode register only changed between transfers
// - check bus busy before starting
// - master and transmit select both set
// - first frame: seven-bit address plus direction
// - clear interrupt flag right after data write
// - slave acknowledges low on ninth clock
// - no acknowledge read as one: end, retry
// - read direction: clear transmit select
// - set handshake enable for receive
// - ack bit one before final byte
// - transmit select one before last read
module ihm_top
  import ihm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [2:0]  dev_addr,
  output logic      [7:0]  dev_wdata,
  output logic             dev_wr,
  output logic             dev_rd,
  input  wire logic [7:0]  dev_rdata
);
  typedef enum logic [4:0] {
    S_IDLE, S_CF_MODE, S_CF_EXT, S_CF_SADDR,
    S_ST_CHK, S_ST_MODE, S_ST_GO, S_ST_WAIT,
    S_TX_DATA, S_TX_CLR, S_TX_WAIT, S_TX_ACK,
    S_RX_TRS, S_RX_ACK_BIT, S_RX_DUMMY,
    S_RD_WAIT, S_RD_CLR, S_RD_PREP, S_RD_DATA,
    S_SP_CLR, S_SP_ACK_CHECK_ENABLE, S_SP_GO
  } ihm_state_t;

  ihm_acc_if  acc ();
  ihm_state_t st_q, st_d;
  ihm_cmd_t   cmd, cmd_q;
  logic [7:0] txd, cfg, rxd_q;
  logic       cmd_valid, nack_q, err_q, link_q, trs_q;
  logic [3:0] status;

  // control word with master held high and interrupt enable and flag held low; transmit, ack check, bus busy and start/stop come from the arguments
  function automatic logic [7:0] ctl_word(input logic transmit_select, input logic ack_check_enable,
                                          input logic bus_busy_flag, input logic start_stop_ctl_bit);
    logic [7:0] w;
    w = 8'h00;
    w[CTL_MASTER]     = 1'b1;
    w[CTL_TRANSMIT]   = transmit_select;
    w[CTL_ACK_CHECK]  = ack_check_enable;
    w[CTL_BUS_BUSY]   = bus_busy_flag;
    w[CTL_START_STOP] = start_stop_ctl_bit;
    return w;
  endfunction : ctl_word

  ihm_wb_slave u_wb (
    .clk       (clk),
    .rst_n     (rst_n),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_dat_i  (wb_dat_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .txd       (txd),
    .cfg       (cfg),
    .cmd_valid (cmd_valid),
    .cmd       (cmd),
    .rxd       (rxd_q),
    .status    (status)
  );

  ihm_dev_port u_port (
    .clk       (clk),
    .rst_n     (rst_n),
    .acc       (acc.port),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .dev_rdata (dev_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // one access per state, repeated in the wait states until the flag is set; the engine itself keeps the bus timing
  wire        busy     = (st_q != S_IDLE);
  wire        done     = acc.done;
  wire [7:0]  rd       = acc.rdata;
  wire        flag_set = rd[CTL_INT_FLAG];
  wire        rw_read  = txd[0];
  wire        one_byte = cfg[4];
  wire [7:0]  mode_w   = {cfg[3], 4'h0, cfg[2:0]};
  wire [7:0]  ext_w    = 8'h01 << EXT_HANDSHAKE;
  wire [7:0]  ack_bit_one = 8'h01 << STA_ACK_BIT;
  wire [7:0]  ctl_run  = ctl_word(trs_q, 1'b1, 1'b1, 1'b1);
  // a config command mid-link would upset the frame bit counter
  wire        cfg_bad  = (cmd == IHM_CMD_CFG) && link_q;

  assign status  = {link_q, err_q, nack_q, busy};
  assign acc.req = busy;
  assign acc.we  = !((st_q == S_ST_CHK) || (st_q == S_ST_WAIT) ||
                     (st_q == S_TX_WAIT) || (st_q == S_TX_ACK) ||
                     (st_q == S_RX_DUMMY) || (st_q == S_RD_WAIT) ||
                     (st_q == S_RD_DATA));

  always_comb begin
    acc.addr  = REG_CTRL;
    acc.wdata = ctl_run;
    unique case (st_q)
      S_CF_MODE:  acc.addr = REG_MODE;
      S_CF_EXT:   acc.addr = REG_EXT;
      S_CF_SADDR: acc.addr = REG_SADDR;
      S_TX_DATA:  acc.addr = REG_DATA;
      S_TX_ACK:   acc.addr = REG_STATUS;
      S_RX_ACK_BIT:  acc.addr = REG_STATUS;
      S_RX_DUMMY: acc.addr = REG_DATA;
      S_RD_PREP:  acc.addr = (cmd_q == IHM_CMD_RDPRE) ? REG_STATUS
                                                      : REG_CTRL;
      S_RD_DATA:  acc.addr = REG_DATA;
      default:    acc.addr = REG_CTRL;
    endcase
    unique case (st_q)
      S_CF_MODE:  acc.wdata = mode_w;
      S_CF_EXT:   acc.wdata = ext_w;
      S_CF_SADDR: acc.wdata = 8'h00;
      S_ST_MODE:  acc.wdata = ctl_word(1'b1, 1'b1, 1'b0, 1'b1);
      S_ST_GO:    acc.wdata = ctl_word(1'b1, 1'b1, 1'b1, 1'b0);
      S_TX_DATA:  acc.wdata = txd;
      S_RX_TRS:   acc.wdata = ctl_word(1'b0, 1'b1, 1'b1, 1'b1);
      S_RX_ACK_BIT:  acc.wdata = one_byte ? ack_bit_one : 8'h00;
      S_RD_PREP:  acc.wdata = (cmd_q == IHM_CMD_RDPRE) ? ack_bit_one
                            : ctl_word(1'b1, 1'b1, 1'b1, 1'b1);
      S_SP_ACK_CHECK_ENABLE:  acc.wdata = ctl_word(trs_q, 1'b0, 1'b1, 1'b1);
      S_SP_GO:    acc.wdata = ctl_word(trs_q, 1'b0, 1'b0, 1'b0);
      default:    acc.wdata = ctl_run;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (cmd_valid && !cfg_bad) begin
        unique case (cmd)
          IHM_CMD_CFG:   st_d = S_CF_MODE;
          IHM_CMD_START: st_d = S_ST_CHK;
          IHM_CMD_WRITE: st_d = S_TX_DATA;
          IHM_CMD_READ,
          IHM_CMD_RDPRE,
          IHM_CMD_RDFIN: st_d = S_RD_WAIT;
          IHM_CMD_STOP:  st_d = S_SP_CLR;
          IHM_CMD_NONE:  st_d = S_IDLE;
        endcase
      end
      S_CF_MODE:  if (done) st_d = S_CF_EXT;
      S_CF_EXT:   if (done) st_d = S_CF_SADDR;
      S_CF_SADDR: if (done) st_d = S_IDLE;
      S_ST_CHK:   if (done) st_d = rd[CTL_BUS_BUSY] ? S_IDLE
                                                    : S_ST_MODE;
      S_ST_MODE:  if (done) st_d = S_ST_GO;
      S_ST_GO:    if (done) st_d = S_ST_WAIT;
      S_ST_WAIT:  if (done && flag_set) st_d = S_TX_DATA;
      S_TX_DATA:  if (done) st_d = S_TX_CLR;
      S_TX_CLR:   if (done) st_d = S_TX_WAIT;
      S_TX_WAIT:  if (done && flag_set) st_d = S_TX_ACK;
      S_TX_ACK:   if (done) begin
        st_d = (cmd_q == IHM_CMD_START && rw_read && !rd[STA_ACK_BIT])
               ? S_RX_TRS : S_IDLE;
      end
      S_RX_TRS:   if (done) st_d = S_RX_ACK_BIT;
      S_RX_ACK_BIT:  if (done) st_d = S_RX_DUMMY;
      S_RX_DUMMY: if (done) st_d = S_IDLE;
      S_RD_WAIT:  if (done && flag_set) st_d = S_RD_CLR;
      S_RD_CLR:   if (done) begin
        st_d = (cmd_q == IHM_CMD_READ) ? S_RD_DATA : S_RD_PREP;
      end
      S_RD_PREP:  if (done) st_d = S_RD_DATA;
      S_RD_DATA:  if (done) st_d = S_IDLE;
      S_SP_CLR:   if (done) st_d = S_SP_ACK_CHECK_ENABLE;
      S_SP_ACK_CHECK_ENABLE:  if (done) st_d = S_SP_GO;
      S_SP_GO:    if (done) st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= S_IDLE;
      cmd_q  <= IHM_CMD_NONE;
      rxd_q  <= 8'h00;
      nack_q <= 1'b0;
      err_q  <= 1'b0;
      link_q <= 1'b0;
      trs_q  <= 1'b1;
    end else begin
      st_q <= st_d;
      if (st_q == S_IDLE && cmd_valid) begin
        cmd_q <= cmd;
        err_q <= cfg_bad;
      end
      if (st_q == S_ST_CHK && done) begin
        err_q  <= rd[CTL_BUS_BUSY];
        nack_q <= 1'b0;
        link_q <= !rd[CTL_BUS_BUSY];
        trs_q  <= 1'b1;
      end
      if (st_q == S_TX_ACK && done) nack_q <= rd[STA_ACK_BIT];
      if (st_q == S_RX_TRS && done) trs_q <= 1'b0;
      if (st_q == S_RD_PREP && done && cmd_q == IHM_CMD_RDFIN) trs_q <= 1'b1;
      if (st_q == S_RD_DATA && done) rxd_q <= rd;
      if (st_q == S_SP_GO && done) link_q <= 1'b0;
    end
  end
  // the engine's interrupt line is not used: polling keeps the host simple
endmodule : ihm_top

/* bench/ihm_props.sv */
// checker on the host controller's wishbone and engine ports
// assumes binding into ihm_top, one clock domain
`timescale 1ns/1ps
module ihm_props
  import ihm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  dev_addr,
  input wire logic [7:0]  dev_wdata,
  input wire logic        dev_wr,
  input wire logic        dev_rd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       acc;
  logic       wr_ctl;
  logic [7:0] last_ctl_q;
  assign acc    = dev_wr | dev_rd;
  assign wr_ctl = dev_wr && dev_addr == REG_CTRL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) last_ctl_q <= 8'h00;
    else if (wr_ctl) last_ctl_q <= dev_wdata;
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("wishbone ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_strobe_excl: assert property (!(dev_wr && dev_rd))
    else $error("engine read and write together");
  chk_access_gap: assert property (acc |=> !acc [*3])
    else $error("engine accesses too close");
  chk_addr_hold: assert property (!acc |->
    $stable(dev_addr) && $stable(dev_wdata))
    else $error("engine address moved without strobe");
  chk_start_mode: assert property (
    wr_ctl && dev_wdata[CTL_BUS_BUSY] && !dev_wdata[CTL_START_STOP] |->
    dev_wdata[CTL_MASTER] && dev_wdata[CTL_TRANSMIT])
    else $error("start without master transmit");
  chk_flag_clear: assert property (
    dev_wr && dev_addr == REG_DATA |->
    ##[4:20] (wr_ctl && !dev_wdata[CTL_INT_FLAG]))
    else $error("flag not cleared after data write");
  chk_stop_order: assert property (
    wr_ctl && !dev_wdata[CTL_BUS_BUSY] && !dev_wdata[CTL_START_STOP] |->
    !last_ctl_q[CTL_ACK_CHECK])
    else $error("stop without ack check cleared");
  cov_start: cover property (wr_ctl && dev_wdata == 8'h3c);
  cov_data_rd: cover property (dev_rd && dev_addr == REG_DATA);
  cov_wb_wr: cover property (wb_ack_o && wb_we_i);
endmodule : ihm_props
bind ihm_top ihm_props i_props (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .dev_addr, .dev_wdata, .dev_wr, .dev_rd);

/* bench/ihm_eng_model.sv */
// register-level model of the two-wire engine behind the host
// assumes host strobes on clk; frames take FRAME cycles, no pins modelled
`timescale 1ns/1ps
module ihm_eng_model
  import ihm_pkg::*;
#(
  parameter int FRAME = 36
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  output logic      [7:0] dev_rdata,
  input  wire logic       nack,
  input  wire logic       bus_ext,
  input  wire logic [7:0] rx_byte
);
  logic [7:0] ctrl_q, sta_q, mode_q, ext_q, sadr_q, tx_q, rxb_q, tx_last;
  logic [5:0] cnt_q;
  logic [1:0] kind_q;
  logic [3:0] rx_cnt_q;
  logic       ack_sent_q;
  logic       irq;
  assign irq = ctrl_q[CTL_INT_ENABLE] & ctrl_q[CTL_INT_FLAG];
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ctrl_q, sta_q, mode_q, ext_q, sadr_q, tx_q, rxb_q, tx_last} <= '0;
      {cnt_q, kind_q, rx_cnt_q, ack_sent_q, dev_rdata} <= '0;
    end else begin
      if (cnt_q != 6'h00) cnt_q <= cnt_q - 6'h01;
      if (cnt_q == 6'h01) begin
        ctrl_q[CTL_INT_FLAG] <= 1'b1;
        sta_q[STA_XFER_DONE] <= 1'b1;
        if (kind_q == 2'h1) begin
          sta_q[STA_ACK_BIT] <= nack;
          tx_last <= tx_q;
        end
        if (kind_q == 2'h2) begin
          rxb_q <= rx_byte;
          sta_q[STA_RX_FULL] <= 1'b1;
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
      if (dev_rd) begin
        case (dev_addr)
          REG_DATA: dev_rdata <= rxb_q;
          REG_CTRL: dev_rdata <= ctrl_q | {5'h00, bus_ext, 2'h0};
          REG_STATUS: dev_rdata <= sta_q;
          default: dev_rdata <= 8'h00;
        endcase
      end
      if (dev_rd && dev_addr == REG_DATA) begin
        sta_q[STA_RX_FULL] <= 1'b0;
        if (!ctrl_q[CTL_TRANSMIT]) begin
          cnt_q <= 6'(FRAME);
          kind_q <= 2'h2;
          ack_sent_q <= sta_q[STA_ACK_BIT];
        end
      end
      if (dev_wr) begin
        case (dev_addr)
          REG_CTRL: begin
            // flag only falls on a written zero
            ctrl_q <= {dev_wdata[7:2], ctrl_q[1] & dev_wdata[1], dev_wdata[0]};
            if (!dev_wdata[CTL_ACK_CHECK]) sta_q[STA_ACK_BIT] <= 1'b0;
            if (dev_wdata[CTL_BUS_BUSY] && !dev_wdata[CTL_START_STOP]) begin
              cnt_q <= 6'h08;
              kind_q <= 2'h0;
            end
          end
          REG_DATA: begin
            tx_q <= dev_wdata;
            if (ctrl_q[CTL_TRANSMIT]) begin
              cnt_q <= 6'(FRAME);
              kind_q <= 2'h1;
            end
          end
          REG_STATUS: sta_q[STA_ACK_BIT] <= dev_wdata[0];
          REG_MODE: mode_q <= dev_wdata;
          REG_EXT: ext_q <= dev_wdata;
          REG_SADDR: sadr_q <= dev_wdata;
          default: ;
        endcase
      end
    end
  end
endmodule : ihm_eng_model

/* bench/test_ihm_top.sv */
// self-checking bench for the host controller with an engine model
// assumes the model answers reads one cycle after the strobe
`timescale 1ns/1ps
module test_ihm_top;
  import ihm_pkg::*;
  logic        clk, rst_n, cyc, stb, we, nack, bus_ext, wb_ack_o, dev_wr, dev_rd;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, q, wb_dat_o;
  logic [2:0]  dev_addr;
  logic [7:0]  dev_wdata, dev_rdata, cfg, txd, rx_byte;
  logic [7:0]  rx_vals [0:15];
  int          err_total, checks, seed, cycles;
  assign rx_byte = rx_vals[i_eng.rx_cnt_q];
  ihm_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata));
  ihm_eng_model i_eng (.clk(clk), .rst_n(rst_n), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .nack(nack), .bus_ext(bus_ext), .rx_byte(rx_byte));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // mode layout: order bit on top, bit count in the low three bits
  function automatic logic [7:0] mode_of(input logic [7:0] c);
    return {c[3], 4'h0, c[2:0]};
  endfunction : mode_of
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // request held until ack is sampled, then a one-cycle gap
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic cmd(input ihm_cmd_t c);
    wb(1'b1, WB_CMD, {29'h0, c});
    repeat (3) @(posedge clk);
    // a hung engine is caught by the cycle ceiling, counted as a mismatch
    do wb(1'b0, WB_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask : cmd
  task automatic rx(input ihm_cmd_t c, input logic [7:0] e);
    cmd(c);
    wb(1'b0, WB_RXD, 32'h0);
    check("rxd", q, {24'h0, e});
  endtask : rx
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 77270;
    {cyc, stb, we, adr, dat, sel, nack, bus_ext, rst_n} = '0;
    foreach (rx_vals[i]) rx_vals[i] = 8'($random(seed));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, WB_CFG, 32'h0);
    check("cfg_reset", q, {24'h0, CFG_RESET});
    wb(1'b1, 5'h14, 32'h5a);
    wb(1'b0, 5'h14, 32'h0);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cfg = (i == 2) ? 8'h00 : 8'($random(seed)) & 8'h0f;
      wb(1'b1, WB_CFG, {24'h0, cfg});
      cmd(IHM_CMD_CFG);
      check("mode", i_eng.mode_q, mode_of(cfg));
      check("handshake", i_eng.ext_q[EXT_HANDSHAKE], 32'h1);
      check("format", i_eng.sadr_q[SADDR_FORMAT], 32'h0);
    end
    txd = {7'($random(seed)), 1'b0};
    wb(1'b1, WB_TXD, {24'h0, txd});
    cmd(IHM_CMD_START);
    check("addr_frame", i_eng.tx_last, txd);
    check("done_flag", i_eng.sta_q[STA_XFER_DONE], 32'h1);
    check("status_ack", q[1], 32'h0);
    for (int k = 0; k < 3; k++) begin
      txd = 8'($random(seed));
      @(posedge clk) nack <= (k == 2);
      wb(1'b1, WB_TXD, {24'h0, txd});
      cmd(IHM_CMD_WRITE);
      check("tx_byte", i_eng.tx_last, txd);
      check("nack", q[1], 32'(k == 2));
    end
    cmd(IHM_CMD_CFG);
    check("cfg_refused", q[2], 32'h1);
    check("cfg_kept", i_eng.mode_q, mode_of(8'h00));
    @(posedge clk) nack <= 1'b0;
    cmd(IHM_CMD_STOP);
    check("ack_cleared", i_eng.sta_q[STA_ACK_BIT], 32'h0);
    check("bus_free", i_eng.ctrl_q[CTL_BUS_BUSY], 32'h0);
    wb(1'b1, WB_TXD, {24'h0, 7'($random(seed)), 1'b1});
    cmd(IHM_CMD_START);
    check("rx_mode", i_eng.ctrl_q[CTL_TRANSMIT], 32'h0);
    rx(IHM_CMD_READ, rx_vals[0]);
    check("ack_low", i_eng.ack_sent_q, 32'h0);
    rx(IHM_CMD_RDPRE, rx_vals[1]);
    rx(IHM_CMD_RDFIN, rx_vals[2]);
    check("last_nack", i_eng.ack_sent_q, 32'h1);
    check("rx_full", i_eng.sta_q[STA_RX_FULL], 32'h0);
    check("frames", i_eng.rx_cnt_q, 32'h3);
    cmd(IHM_CMD_STOP);
    cfg = 8'h10;
    wb(1'b1, WB_CFG, {24'h0, cfg});
    cmd(IHM_CMD_CFG);
    wb(1'b1, WB_TXD, {24'h0, 7'($random(seed)), 1'b1});
    cmd(IHM_CMD_START);
    check("one_nack", i_eng.ack_sent_q, 32'h1);
    rx(IHM_CMD_RDFIN, rx_vals[3]);
    check("one_frame", i_eng.rx_cnt_q, 32'h4);
    cmd(IHM_CMD_STOP);
    @(posedge clk) bus_ext <= 1'b1;
    cmd(IHM_CMD_START);
    check("busy_err", q[2], 32'h1);
    check("no_start", i_eng.ctrl_q[CTL_BUS_BUSY], 32'h0);
    report_and_stop();
  end
endmodule : test_ihm_top
